//--- common/ldmpg_cfg.svh
// Offsets, field positions, reset values and bus constants of the mode and supply-good register bank
`ifndef LDMPG_CFG_SVH
`define LDMPG_CFG_SVH

// ==========================================
// Register offsets
`define LDMPG_TORCH_RST_ADDR 8'h00
`define LDMPG_MODE_FLASH_ADDR 8'h01
`define LDMPG_MODE_MIRROR_ADDR 8'h02

// ==========================================
// Reset values
`define LDMPG_TORCH_RST_DEF 8'h0A
`define LDMPG_MODE_FLASH_DEF 8'h10
`define LDMPG_MIRROR_LOW_DEF 6'h08

// ==========================================
// Field positions
`define LDMPG_SOFT_RESET_BIT 7
`define LDMPG_OUTER_MSB 5
`define LDMPG_OUTER_LSB 3
`define LDMPG_CENTER_MSB 2
`define LDMPG_CENTER_LSB 0
`define LDMPG_MODE_MSB 7
`define LDMPG_MODE_LSB 6
`define LDMPG_FLASH_MSB 5
`define LDMPG_FLASH_LSB 0
`define LDMPG_FORCE_VM_BIT 5

// ==========================================
// Mode codes and current steps
`define LDMPG_MODE_SHUTDOWN 2'h0
`define LDMPG_MODE_VOLTAGE 2'h3
`define LDMPG_STEP_MA 10'h019
`define LDMPG_BOOST6_MA 10'h0E1
`define LDMPG_BOOST7_MA 10'h145

// ==========================================
// Serial bus
`define LDMPG_DEV_ADDR_DEF 7'h2A
`define LDMPG_BITS_PER_BYTE 4'h8

`endif

//--- common/ldmpg_pkg.sv
// Types shared by the mode and supply-good register bank
package ldmpg_pkg;

    // ==========================================
    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WRITE,
        ST_READ
    } ldmpg_state_e;

    typedef logic [7:0] ldmpg_byte_t;

endpackage

//--- rtl/ldmpg_top.sv
// Mode control, supply-good pin and first configuration registers behind a serial slave
//
// Contract
// R1 - Supply-good monitor runs only when mode is 11 or force voltage mode is set.
// R2 - In shutdown, pin driven low for push-pull type, released for open-drain type.
// R3 - Push-pull pin follows flag; open-drain pin released for 0, low for 1.
// R4 - Flag true while output in window; false whenever voltage mode is suspended.
// R5 - Flag held low while energy flows back to the input.
// R6 - Down mode entered when input reaches output; left when input 200 mV lower.
// R7 - Pulse skipping follows its enable, but is always on in down mode.
// R8 - Mode 00 gives shutdown only with force voltage mode clear and no light mode.
// R9 - Shutdown stops switching, disconnects load, floats sinks, discharges output.
// R10 - Writing 1 to the reset bit restores defaults in every register.
// R11 - Outer torch current: 25 mA per code step, 0 to 175 mA.
// R12 - Centre torch current same steps; codes 6 and 7 give 225/325 mA with mask.
// R13 - Both torch fields zero: LEDs off, voltage regulation at set output voltage.
// R14 - Register 0x00: reset bit 7, torch fields below; reset value sets bits 3 and 1.
// R15 - Register 0x01: mode in 7:6, flash current in 5:0; reset sets bit 4.
// R16 - Mode codes: 00 shutdown, 01 video light, 10 flash, 11 voltage source.
// R17 - Writing mode bits of 0x01 also updates mirrored mode bits of 0x02.
// R18 - Host uses single-byte reads and writes addressed by register number.
`timescale 1ns/1ps
`include "ldmpg_cfg.svh"

module ldmpg_top #(
    parameter logic [6:0] DEV_ADDR = `LDMPG_DEV_ADDR_DEF
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Configuration straps and analog indications
    input wire logic output_stage_type_in,
    input wire logic light_load_skip_enable_in,
    input wire logic tx_mask_in,
    input wire logic output_in_window_in,
    input wire logic energy_return_in,
    input wire logic vin_ge_vout_in,
    input wire logic vin_below_vout_in,
    // Supply-good pin and status
    output logic general_purpose_supply_good_pin_out,
    output logic general_purpose_supply_good_pin_oe_out,
    output logic supply_good_flag_out,
    output logic supply_good_monitor_en_out,
    // Converter control
    output logic shutdown_out,
    output logic switching_en_out,
    output logic load_disconnect_out,
    output logic led_sink_pins_hiz_out,
    output logic output_discharge_out,
    output logic down_mode_out,
    output logic pulse_skip_active_out,
    output logic leds_off_vreg_out,
    output logic [1:0] mode_out,
    output logic force_voltage_mode_out,
    // Current settings
    output logic [9:0] torch_current_outer_pair_ma_out,
    output logic [9:0] torch_current_center_ma_out,
    output logic [5:0] flash_current_center_out,
    output logic [4:0] flash_current_outer_out
);

    // ==========================================
    // Current decode
    function automatic logic [9:0] step_ma(input logic [2:0] code);
        step_ma = 10'(code) * `LDMPG_STEP_MA;
    endfunction

    // ==========================================
    // Input synchronisers
    logic [8:0] meta_reg;
    logic [8:0] sync_reg;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= 9'h003;
            sync_reg <= 9'h003;
        end else begin
            meta_reg <= {vin_below_vout_in, vin_ge_vout_in, energy_return_in, output_in_window_in,
                tx_mask_in, light_load_skip_enable_in, output_stage_type_in, sda_in, scl_in};
            sync_reg <= meta_reg;
        end
    end

    wire logic scl_s = sync_reg[0];
    wire logic sda_s = sync_reg[1];
    wire logic stage_od = sync_reg[2];
    wire logic skip_en = sync_reg[3];
    wire logic tx_mask = sync_reg[4];
    wire logic in_window = sync_reg[5];
    wire logic energy_ret = sync_reg[6];
    wire logic vin_ge = sync_reg[7];
    wire logic vin_below = sync_reg[8];

    logic scl_d_reg;
    logic sda_d_reg;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    wire logic start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire logic stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire logic scl_rise = scl_s & ~scl_d_reg;
    wire logic scl_fall = ~scl_s & scl_d_reg;

    // ==========================================
    // Serial slave
    ldmpg_pkg::ldmpg_state_e state_reg;
    ldmpg_pkg::ldmpg_byte_t rx_reg;
    ldmpg_pkg::ldmpg_byte_t tx_reg;
    ldmpg_pkg::ldmpg_byte_t ptr_reg;
    logic [3:0] cnt_reg;
    logic ack_reg;
    logic rw_reg;
    logic nack_reg;
    logic oe_reg;

    logic [7:0] torch_reg;
    logic [7:0] modefl_reg;
    logic [5:0] mirror_reg;

    wire logic byte_done = scl_fall & ~ack_reg & (cnt_reg == `LDMPG_BITS_PER_BYTE);
    wire logic addr_hit = rx_reg[7:1] == DEV_ADDR;
    wire logic wr_go = byte_done & (state_reg == ldmpg_pkg::ST_WRITE);
    wire logic [7:0] rd_data = (ptr_reg == `LDMPG_TORCH_RST_ADDR) ? torch_reg :
                               (ptr_reg == `LDMPG_MODE_FLASH_ADDR) ? modefl_reg :
                               (ptr_reg == `LDMPG_MODE_MIRROR_ADDR) ? {modefl_reg[7:6], mirror_reg} :
                               8'h00;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ldmpg_pkg::ST_IDLE;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= ldmpg_pkg::ST_ADDR;
            cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ldmpg_pkg::ST_IDLE;
            ack_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (state_reg != ldmpg_pkg::ST_IDLE) begin
            if (scl_rise) begin
                if (ack_reg) begin
                    nack_reg <= sda_s;
                end else begin
                    rx_reg <= {rx_reg[6:0], sda_s};
                    tx_reg <= {tx_reg[6:0], 1'b0};
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end else if (byte_done) begin
                ack_reg <= 1'b1;
                unique case (state_reg)
                    ldmpg_pkg::ST_ADDR: begin
                        oe_reg <= addr_hit;
                        rw_reg <= rx_reg[0];
                        if (!addr_hit) begin
                            state_reg <= ldmpg_pkg::ST_IDLE;
                        end
                    end
                    ldmpg_pkg::ST_REG: begin
                        ptr_reg <= rx_reg; // R18
                        oe_reg <= 1'b1;
                    end
                    ldmpg_pkg::ST_WRITE: begin
                        ptr_reg <= ptr_reg + 8'h01;
                        oe_reg <= 1'b1;
                    end
                    ldmpg_pkg::ST_READ: begin
                        ptr_reg <= ptr_reg + 8'h01;
                        oe_reg <= 1'b0;
                    end
                    ldmpg_pkg::ST_IDLE: begin
                        oe_reg <= 1'b0;
                    end
                endcase
            end else if (scl_fall && ack_reg) begin
                ack_reg <= 1'b0;
                cnt_reg <= 4'h0;
                oe_reg <= 1'b0;
                unique case (state_reg)
                    ldmpg_pkg::ST_ADDR: begin
                        state_reg <= rw_reg ? ldmpg_pkg::ST_READ : ldmpg_pkg::ST_REG;
                        tx_reg <= rd_data;
                        oe_reg <= rw_reg & ~rd_data[7];
                    end
                    ldmpg_pkg::ST_REG: begin
                        state_reg <= ldmpg_pkg::ST_WRITE;
                    end
                    ldmpg_pkg::ST_WRITE: begin
                        state_reg <= ldmpg_pkg::ST_WRITE;
                    end
                    ldmpg_pkg::ST_READ: begin
                        state_reg <= nack_reg ? ldmpg_pkg::ST_IDLE : ldmpg_pkg::ST_READ;
                        tx_reg <= rd_data;
                        oe_reg <= ~nack_reg & ~rd_data[7];
                    end
                    ldmpg_pkg::ST_IDLE: begin
                        state_reg <= ldmpg_pkg::ST_IDLE;
                    end
                endcase
            end else if (scl_fall && state_reg == ldmpg_pkg::ST_READ) begin
                oe_reg <= ~tx_reg[7];
            end
        end
    end

    // ==========================================
    // Register file
    wire logic wr_torch = wr_go & (ptr_reg == `LDMPG_TORCH_RST_ADDR);
    wire logic wr_modefl = wr_go & (ptr_reg == `LDMPG_MODE_FLASH_ADDR);
    wire logic wr_mirror = wr_go & (ptr_reg == `LDMPG_MODE_MIRROR_ADDR);
    wire logic soft_reset = wr_torch & rx_reg[`LDMPG_SOFT_RESET_BIT]; // R10
    wire logic [7:0] modefl_next = wr_modefl ? rx_reg : // R17
                                   wr_mirror ? {rx_reg[7:6], modefl_reg[5:0]} : modefl_reg;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            torch_reg <= `LDMPG_TORCH_RST_DEF; // R14
            modefl_reg <= `LDMPG_MODE_FLASH_DEF; // R15
            mirror_reg <= `LDMPG_MIRROR_LOW_DEF;
        end else if (soft_reset) begin
            torch_reg <= `LDMPG_TORCH_RST_DEF; // R10
            modefl_reg <= `LDMPG_MODE_FLASH_DEF;
            mirror_reg <= `LDMPG_MIRROR_LOW_DEF;
        end else begin
            torch_reg <= wr_torch ? rx_reg : torch_reg;
            modefl_reg <= modefl_next; // R15
            mirror_reg <= wr_mirror ? rx_reg[5:0] : mirror_reg;
        end
    end

    // ==========================================
    // Mode decode
    wire logic [1:0] mode = modefl_reg[`LDMPG_MODE_MSB:`LDMPG_MODE_LSB]; // R16
    wire logic force_vm = mirror_reg[`LDMPG_FORCE_VM_BIT];
    wire logic [2:0] outer_code = torch_reg[`LDMPG_OUTER_MSB:`LDMPG_OUTER_LSB];
    wire logic [2:0] center_code = torch_reg[`LDMPG_CENTER_MSB:`LDMPG_CENTER_LSB];
    wire logic vm_active = (mode == `LDMPG_MODE_VOLTAGE) | force_vm; // R1
    wire logic shutdown = (mode == `LDMPG_MODE_SHUTDOWN) & ~force_vm; // R8
    wire logic flag_next = vm_active & in_window & ~energy_ret; // R4 R5
    wire logic down_next = ~vm_active ? 1'b0 : vin_ge ? 1'b1 : vin_below ? 1'b0 : down_mode_out; // R6
    wire logic pin_level = shutdown ? 1'b0 : ~stage_od & flag_next; // R2 R3
    wire logic pin_oe = shutdown ? ~stage_od : (~stage_od | flag_next); // R2 R3
    wire logic [9:0] center_ma = (tx_mask && center_code == 3'h6) ? `LDMPG_BOOST6_MA :
                                 (tx_mask && center_code == 3'h7) ? `LDMPG_BOOST7_MA :
                                 step_ma(center_code); // R12

    // ==========================================
    // Registered outputs
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            general_purpose_supply_good_pin_out <= 1'b0;
            general_purpose_supply_good_pin_oe_out <= 1'b0;
            supply_good_flag_out <= 1'b0;
            supply_good_monitor_en_out <= 1'b0;
            shutdown_out <= 1'b1;
            switching_en_out <= 1'b0;
            load_disconnect_out <= 1'b1;
            led_sink_pins_hiz_out <= 1'b1;
            output_discharge_out <= 1'b1;
            down_mode_out <= 1'b0;
            pulse_skip_active_out <= 1'b0;
            leds_off_vreg_out <= 1'b0;
            mode_out <= 2'h0;
            force_voltage_mode_out <= 1'b0;
            torch_current_outer_pair_ma_out <= 10'h000;
            torch_current_center_ma_out <= 10'h000;
            flash_current_center_out <= 6'h00;
            flash_current_outer_out <= 5'h00;
        end else begin
            general_purpose_supply_good_pin_out <= pin_level; // R3
            general_purpose_supply_good_pin_oe_out <= pin_oe; // R2
            supply_good_flag_out <= flag_next; // R4
            supply_good_monitor_en_out <= vm_active; // R1
            shutdown_out <= shutdown; // R8
            switching_en_out <= ~shutdown; // R9
            load_disconnect_out <= shutdown; // R9
            led_sink_pins_hiz_out <= shutdown; // R9
            output_discharge_out <= shutdown; // R9
            down_mode_out <= down_next; // R6
            pulse_skip_active_out <= down_next | skip_en; // R7
            leds_off_vreg_out <= (outer_code == 3'h0) & (center_code == 3'h0); // R13
            mode_out <= mode;
            force_voltage_mode_out <= force_vm;
            torch_current_outer_pair_ma_out <= step_ma(outer_code); // R11
            torch_current_center_ma_out <= center_ma; // R12
            flash_current_center_out <= modefl_reg[`LDMPG_FLASH_MSB:`LDMPG_FLASH_LSB];
            flash_current_outer_out <= mirror_reg[4:0];
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_reg;

endmodule

//--- tb/ldmpg_host.sv
// Serial bus host model: drives the clock and the open-drain data line of the register bank
`timescale 1ns/1ps
`include "ldmpg_cfg.svh"

module ldmpg_host #(
    parameter logic [6:0] DEV = `LDMPG_DEV_ADDR_DEF
) (
    // Clock and device side
    input wire logic clock_in,
    input wire logic sda_oe_in,
    // Bus lines
    output logic scl_out,
    output logic sda_out
);
    logic drv = 1'b1;
    initial scl_out = 1'b1;
    // Pull-up unless either party pulls low
    assign sda_out = drv & ~sda_oe_in;

    // ==========================================
    // Bit level
    task automatic w(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // Data set while clock low, changed while high only for start and stop
    task automatic sq(input logic a, input logic b, output logic r);
        scl_out <= 1'b0;
        w(4);
        drv <= a;
        w(4);
        scl_out <= 1'b1;
        w(8);
        r = sda_out;
        drv <= b;
        w(8);
    endtask
    task automatic xf(input logic [7:0] d, output logic [7:0] q, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) sq(d[i], d[i], q[i]);
        sq(1'b1, 1'b1, r);
        ak = ~r;
    endtask

    // ==========================================
    // Single-byte register access
    task automatic wr(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic k1, k2, k3, r;
        sq(1'b1, 1'b0, r);
        xf({dv, 1'b0}, q, k1);
        xf(a, q, k2);
        xf(d, q, k3);
        sq(1'b0, 1'b1, r);
        ok = k1 & k2 & k3;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
        logic [7:0] x;
        logic k1, k2, k3, k4, r;
        sq(1'b1, 1'b0, r);
        xf({DEV, 1'b0}, x, k1);
        xf(a, x, k2);
        sq(1'b1, 1'b0, r);
        xf({DEV, 1'b1}, x, k3);
        xf(8'hFF, q, k4);
        sq(1'b0, 1'b1, r);
        ok = k1 & k2 & k3;
    endtask
endmodule

//--- tb/ldmpg_checker.sv
// Concurrent checks on mode, supply-good pin and converter control outputs
`timescale 1ns/1ps

module ldmpg_checker (
    // Clock, reset and straps
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic output_stage_type_in,
    input wire logic energy_return_in,
    input wire logic vin_ge_vout_in,
    // Observed outputs
    input wire logic general_purpose_supply_good_pin_out,
    input wire logic general_purpose_supply_good_pin_oe_out,
    input wire logic supply_good_flag_out,
    input wire logic supply_good_monitor_en_out,
    input wire logic shutdown_out,
    input wire logic switching_en_out,
    input wire logic load_disconnect_out,
    input wire logic led_sink_pins_hiz_out,
    input wire logic output_discharge_out,
    input wire logic down_mode_out,
    input wire logic pulse_skip_active_out,
    input wire logic [1:0] mode_out,
    input wire logic force_voltage_mode_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire vm = (mode_out == 2'h3) || force_voltage_mode_out;
    wire pin_oe = general_purpose_supply_good_pin_oe_out;
    wire pin = general_purpose_supply_good_pin_out;

    // ==========================================
    // Properties
    property p_mon; $stable(vm) |-> supply_good_monitor_en_out == vm; endproperty
    a_mon: assert property (p_mon) else $error("monitor enable wrong");
    property p_pp;
        (!output_stage_type_in)[*4] ##0 ($stable(supply_good_flag_out) && $stable(shutdown_out))
            |-> pin_oe && pin == supply_good_flag_out;
    endproperty
    a_pp: assert property (p_pp) else $error("push-pull pin wrong");
    property p_od;
        output_stage_type_in[*4] ##0 ($stable(supply_good_flag_out) && $stable(shutdown_out))
            |-> pin_oe == supply_good_flag_out && !pin;
    endproperty
    a_od: assert property (p_od) else $error("open-drain pin wrong");
    property p_off; !vm && !$past(vm) |-> !supply_good_flag_out; endproperty
    a_off: assert property (p_off) else $error("flag set outside voltage mode");
    property p_er; energy_return_in[*5] |-> !supply_good_flag_out; endproperty
    a_er: assert property (p_er) else $error("flag set during energy return");
    property p_down; (vm && vin_ge_vout_in)[*5] |-> down_mode_out; endproperty
    a_down: assert property (p_down) else $error("down mode not entered");
    property p_skip; down_mode_out[*2] |-> pulse_skip_active_out; endproperty
    a_skip: assert property (p_skip) else $error("skip off in down mode");
    property p_sd;
        $stable(mode_out) && $stable(force_voltage_mode_out) |-> shutdown_out == (mode_out == 2'h0 && !force_voltage_mode_out);
    endproperty
    a_sd: assert property (p_sd) else $error("shutdown decode wrong");
    property p_eff;
        shutdown_out[*2] |-> !switching_en_out && load_disconnect_out && led_sink_pins_hiz_out && output_discharge_out;
    endproperty
    a_eff: assert property (p_eff) else $error("shutdown effects missing");
    c_flag: cover property ($rose(supply_good_flag_out));
    c_down: cover property ($rose(down_mode_out));
    c_wake: cover property ($fell(shutdown_out));
endmodule

bind ldmpg_top ldmpg_checker u_chk (.*);

//--- tb/tb.sv
// Self-checking bench for the mode and supply-good register bank
`timescale 1ns/1ps
`include "ldmpg_cfg.svh"

module tb;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [6:0] straps = 7'h00;
    wire scl_in, sda_in, output_stage_type_in, light_load_skip_enable_in, tx_mask_in, output_in_window_in;
    wire energy_return_in, vin_ge_vout_in, vin_below_vout_in;
    logic sda_out, sda_oe_out, general_purpose_supply_good_pin_out, general_purpose_supply_good_pin_oe_out;
    logic supply_good_flag_out, supply_good_monitor_en_out, shutdown_out, switching_en_out, load_disconnect_out;
    logic led_sink_pins_hiz_out, output_discharge_out, down_mode_out, pulse_skip_active_out, leds_off_vreg_out;
    logic force_voltage_mode_out;
    logic [1:0] mode_out;
    logic [9:0] torch_current_outer_pair_ma_out, torch_current_center_ma_out;
    logic [5:0] flash_current_center_out;
    logic [4:0] flash_current_outer_out;
    int n_mismatch = 0;
    int comparisons = 0;
    logic ok;
    logic [7:0] q;
    assign {output_stage_type_in, light_load_skip_enable_in, tx_mask_in, output_in_window_in} = straps[6:3];
    assign {energy_return_in, vin_ge_vout_in, vin_below_vout_in} = straps[2:0];
    always #2 clock_in = ~clock_in;
    ldmpg_top dut (.*);
    ldmpg_host host (.clock_in(clock_in), .sda_oe_in(sda_oe_out), .scl_out(scl_in), .sda_out(sda_in));

    // ==========================================
    // Helpers
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stl();
        repeat (6) @(posedge clock_in);
    endtask
    task automatic set(input logic [6:0] v);
        @(posedge clock_in);
        straps <= v;
        stl();
    endtask
    task automatic wrc(input logic [7:0] a, input logic [7:0] d);
        host.wr(`LDMPG_DEV_ADDR_DEF, a, d, ok);
        chk(10'(ok), 10'h001);
        stl();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, q, ok);
        chk({1'b0, ok, q}, {2'h1, e});
    endtask
    wire [1:0] pg = {general_purpose_supply_good_pin_oe_out, general_purpose_supply_good_pin_out};

    // ==========================================
    // Scenarios
    task automatic t_currents();
        rdc(8'h00, 8'h0A);
        rdc(8'h01, 8'h10);
        chk(torch_current_center_ma_out, 10'h032);
        chk(10'(shutdown_out), 10'h001);
        chk(10'(sda_out), 10'h000);
        wrc(8'h01, 8'h40);
        for (int c = 0; c < 8; c++) begin
            wrc(8'h00, {2'h0, 3'(c), 3'(c)});
            chk(torch_current_outer_pair_ma_out, 10'(c) * 10'h019);
            chk(torch_current_center_ma_out, 10'(c) * 10'h019);
            chk(10'(leds_off_vreg_out), 10'(c == 0));
        end
        set(7'h10);
        chk(torch_current_center_ma_out, 10'h145);
        wrc(8'h00, 8'h36);
        chk(torch_current_center_ma_out, 10'h0E1);
        chk(torch_current_outer_pair_ma_out, 10'h096);
        rdc(8'h00, 8'h36);
        $display("test currents finished");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wrc(8'h01, {2'(m), 6'h2A});
            chk(10'(mode_out), 10'(m));
            chk(10'(shutdown_out), 10'(m == 0));
            chk(10'(supply_good_monitor_en_out), 10'(m == 3));
            rdc(8'h02, {2'(m), 6'h08});
        end
        chk(10'(flash_current_center_out), 10'h02A);
        wrc(8'h02, 8'h28);
        chk({8'h00, shutdown_out, supply_good_monitor_en_out}, 10'h001);
        wrc(8'h02, 8'h08);
        chk({8'h00, shutdown_out, supply_good_monitor_en_out}, 10'h002);
        $display("test modes finished");
    endtask
    task automatic t_pg();
        wrc(8'h01, 8'hC0);
        set(7'h08);
        chk(10'(supply_good_flag_out), 10'h001);
        chk(10'(pg), 10'h003);
        set(7'h48);
        chk(10'(pg), 10'h002);
        set(7'h4C);
        chk(10'(supply_good_flag_out), 10'h000);
        chk(10'(pg), 10'h000);
        wrc(8'h01, 8'h00);
        chk(10'(pg), 10'h000);
        set(7'h08);
        chk(10'(pg), 10'h002);
        chk(10'(supply_good_flag_out), 10'h000);
        $display("test supply good finished");
    endtask
    task automatic t_down();
        wrc(8'h01, 8'hC0);
        set(7'h02);
        chk({8'h00, down_mode_out, pulse_skip_active_out}, 10'h003);
        set(7'h00);
        chk(10'(down_mode_out), 10'h001);
        set(7'h01);
        chk({8'h00, down_mode_out, pulse_skip_active_out}, 10'h000);
        set(7'h21);
        chk(10'(pulse_skip_active_out), 10'h001);
        $display("test down mode finished");
    endtask
    task automatic t_soft();
        wrc(8'h01, 8'h85);
        wrc(8'h02, 8'h3F);
        wrc(8'h00, 8'h80);
        rdc(8'h00, 8'h0A);
        rdc(8'h01, 8'h10);
        rdc(8'h02, 8'h08);
        chk(10'(flash_current_outer_out), 10'h008);
        chk(10'(force_voltage_mode_out), 10'h000);
        host.wr(7'h15, 8'h01, 8'hC0, ok);
        chk({9'h000, ok}, 10'h000);
        chk(10'(mode_out), 10'h000);
        rdc(8'h05, 8'h00);
        $display("test soft reset finished");
    endtask

    // ==========================================
    // Sequence, watchdog and verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        t_currents();
        t_modes();
        t_pg();
        t_down();
        t_soft();
        end_of_test();
    end
    initial begin
        repeat (80000) @(posedge clock_in);
        n_mismatch++;
        end_of_test();
    end
endmodule
